// ### pmac_regs.vh
// Register offsets, field positions, reset values and timing for the block.
`ifndef PMAC_REGS_VH
`define PMAC_REGS_VH
// Word offsets on the Avalon-MM slave.
`define PMAC_A_CTRL    4'h0
`define PMAC_A_MEAS    4'h1
`define PMAC_A_WAIT    4'h2
`define PMAC_A_THR     4'h3
`define PMAC_A_TEMP    4'h4
`define PMAC_A_STAT    4'h5
`define PMAC_A_RES     4'h6
// Control and temperature register fields.
`define PMAC_MODE      1:0
`define PMAC_ATYPE     3:2
`define PMAC_LATCH     4
`define PMAC_AOSEL     7:5
`define PMAC_STD       9:8
`define PMAC_TTHR      7:0
`define PMAC_FILT      15:8
// Reset values.
`define PMAC_CTRL_RST  10'h000
`define PMAC_MEAS_RST  16'h003C
`define PMAC_WAIT_RST  16'h00F0
`define PMAC_FILT_RST  8'h02
// Control modes, alarm types, analog selections, standards.
`define PMAC_M_TIME    2'h0
`define PMAC_M_EXT     2'h1
`define PMAC_M_KEY     2'h2
`define PMAC_M_AUTO    2'h3
`define PMAC_T_STD     2'h0
`define PMAC_T_FILT    2'h1
`define PMAC_T_TEMP    2'h2
`define PMAC_O_SEQ     3'h4
`define PMAC_O_SEQ2    3'h5
`define PMAC_O_NAS     3'h6
`define PMAC_O_GOST    3'h7
`define PMAC_S_NAS     2'h2
// Timing in seconds and the clock rate.
`define PMAC_CLK_HZ    50000000
`define PMAC_ADJ_S     16'h0003
`define PMAC_FIRST_S   16'h003C
`define PMAC_AMIN_S    16'h002D
`define PMAC_AMAX_S    16'h012C
`define PMAC_SEQS_S    16'h0002
`define PMAC_SEQF_S    16'h0002
`define PMAC_SEQP_S    16'h0004
// Loop current levels in microamps, and the highest ISO class.
`define PMAC_UA_4      16'h0FA0
`define PMAC_UA_SPAN   32'h00003E80
`define PMAC_ISO_MAX   8'h1A
`define PMAC_UA_19     16'h4A38
`define PMAC_UA_STEP   16'h07D0
`define PMAC_UA_5      16'h1388
`define PMAC_UA_1      16'h03E8
`define PMAC_UA_HALF   16'h01F4
`define PMAC_UA_20     16'h4E20
`endif

// ### pmac_smooth.v
// Alarm smoothing filter for the four size-class values.
`timescale 1ns/1ps
`default_nettype none
module pmac_smooth (
  input  wire        clk,
  input  wire        reset,
  input  wire        upd,
  input  wire        bypass,
  input  wire [7:0]  fk,
  input  wire [31:0] x,
  output reg  [31:0] s_int
);
  reg [63:0] s_r;
  reg        seeded_r;
  integer    i;

  // One filter step in 8.8 fixed point; split by sign to stay unsigned.
  function [15:0] step;
    input [15:0] s;
    input [7:0]  xv;
    input [7:0]  k;
    reg   [15:0] xs;
    begin
      xs = {xv, 8'h00};
      if (xs >= s)
        step = s + (xs - s) / {8'h00, k};
      else
        step = s - (s - xs) / {8'h00, k};
    end
  endfunction

  // Integer part of one filter step, which is all the alarm compare needs.
  function [7:0] step_int;
    input [15:0] s;
    input [7:0]  xv;
    input [7:0]  k;
    reg   [15:0] t;
    begin
      t        = step(s, xv, k);
      step_int = t[15:8];
    end
  endfunction

  // A factor of one, a bypass condition or the first sample loads directly.
  always @(posedge clk) begin
    if (reset) begin
      s_r      <= 64'h0;
      seeded_r <= 1'b0;
      s_int    <= 32'h0;
    end else if (upd) begin
      seeded_r <= 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (bypass || fk <= 8'h01 || !seeded_r) begin // R18 R17
          s_r[i*16 +: 16]  <= {x[i*8 +: 8], 8'h00};
          s_int[i*8 +: 8]  <= x[i*8 +: 8];
        end else begin
          s_r[i*16 +: 16]  <= step(s_r[i*16 +: 16], x[i*8 +: 8], fk); // R17
          s_int[i*8 +: 8]  <= step_int(s_r[i*16 +: 16], x[i*8 +: 8], fk);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### pmac_top.v
// Measurement scheduling, alarm evaluation and loop current output.
// What this block does
// (R01) Frame eight encodes three alarm flags
// (R02) Start measuring at power-up, result after minute
// (R03) Timed mode: measure, wait, repeat
// (R04) Laser adjustment precedes every measurement
// (R05) External mode: start on input release
// (R06) External mode: stop when input grounded
// (R07) Key mode: each press toggles measurement
// (R08) Auto mode: earliest end 45 s, count reached
// (R09) Auto mode: end at 300 s, unsecured
// (R10) Standard alarm: any class above threshold
// (R11) Filter alarm: all enabled classes below
// (R12) Temperature alarm above threshold, zero disables
// (R13) Zero threshold excludes class; all zero none
// (R14) All measured values zero holds alarm; the code holds it only for standard and filter types
// (R15) Standard and filter share thresholds
// (R16) Alarm auto-clears or latches until acknowledged
// (R17) Alarm uses smoothed values, factor 1..255
// (R18) Smoothing bypassed on zero flow or class
// (R19) Single class output linear, 4..20 mA
// (R20) Sequential output sends all classes
// (R21) Extended sequence adds flag frames
// (R22) NAS or GOST selection forces that standard
// (R23) Sequence: start, classes, then pause
// (R24) Sequential output only for ISO and SAE
// (R25) Sequence timings are configurable constants
// (R26) Alarm bit updates at measurement end
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmac_regs.vh"
module pmac_top #(
  parameter SEC_CYC = `PMAC_CLK_HZ
) (
  input  wire        clk,
  input  wire        reset,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        ctl_in,
  input  wire        key_meas,
  input  wire        key_ack,
  input  wire [31:0] class_val,
  input  wire [7:0]  nas_class,
  input  wire [7:0]  gost_class,
  input  wire [7:0]  temp_val,
  input  wire        flow_zero,
  input  wire        count_ok,
  input  wire [2:0]  flags6,
  input  wire [2:0]  flags7,
  input  wire        rise_flag,
  output reg         meas_on,
  output reg         laser_adj,
  output reg         result_stb,
  output reg         result_unsec,
  output reg         alarm_out,
  output reg  [15:0] iout_ua
);
  localparam S_IDLE = 2'h0;
  localparam S_ADJ  = 2'h1;
  localparam S_MEAS = 2'h2;
  localparam S_WAIT = 2'h3;
  localparam P_START = 4'h0;
  localparam P_PAUSE = 4'h8;

  reg [9:0]  ctrl_r;
  reg [15:0] meas_r;
  reg [15:0] wait_r;
  reg [31:0] thr_r;
  reg [7:0]  tthr_r;
  reg [7:0]  filt_r;
  reg [31:0] div_r;
  reg        tick_r;
  reg [1:0]  st_r;
  reg [1:0]  st_nxt;
  reg [15:0] sec_r;
  reg        first_r;
  reg        ctl_prev_r;
  reg        done_nxt;
  reg        unsec_nxt;
  reg        eval_r;
  reg [31:0] res_r;
  reg [3:0]  ph_r;
  reg [15:0] psec_r;
  reg [15:0] lvl_nxt;
  reg        cond;
  reg        std_c;
  reg        filt_c;
  reg        any_en;
  integer    i;
  wire [31:0] sm_int;
  wire [1:0]  mode  = ctrl_r[`PMAC_MODE];
  wire [1:0]  atype = ctrl_r[`PMAC_ATYPE];
  wire [2:0]  aosel = ctrl_r[`PMAC_AOSEL];
  wire        ctl_gnd = !ctl_in;

  // Word-per-class current for ISO or SAE ordinal numbers, capped at 26.
  function [15:0] iso_ua;
    input [7:0] c;
    reg   [7:0] k;
    reg   [31:0] t;
    begin
      k = (c > `PMAC_ISO_MAX) ? `PMAC_ISO_MAX : c;
      t = {24'h0, k} * `PMAC_UA_SPAN / {24'h0, `PMAC_ISO_MAX};
      iso_ua = `PMAC_UA_4 + t[15:0];
    end
  endfunction

  // Flag frame: 19 mA with no flag down to 5 mA with all three set.
  function [15:0] flag_ua;
    input [2:0] v;
    reg   [15:0] t;
    begin
      t = {13'h0, v} * `PMAC_UA_STEP;
      flag_ua = `PMAC_UA_19 - t;
    end
  endfunction

  // Seconds tick; the divider is a parameter so simulation can shorten it.
  always @(posedge clk) begin
    if (reset) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else if (div_r == SEC_CYC - 1) begin
      div_r  <= 32'h0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // Avalon slave: waitrequest drops for one cycle, readdata is set on the same edge.
  always @(posedge clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_r          <= `PMAC_CTRL_RST;
      meas_r          <= `PMAC_MEAS_RST;
      wait_r          <= `PMAC_WAIT_RST;
      thr_r           <= 32'h0;
      tthr_r          <= 8'h00;
      filt_r          <= `PMAC_FILT_RST;
    end else if (avs_waitrequest && (avs_read || avs_write)) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `PMAC_A_CTRL: avs_readdata <= {22'h0, ctrl_r};
        `PMAC_A_MEAS: avs_readdata <= {16'h0, meas_r};
        `PMAC_A_WAIT: avs_readdata <= {16'h0, wait_r};
        `PMAC_A_THR:  avs_readdata <= thr_r;
        `PMAC_A_TEMP: avs_readdata <= {16'h0, filt_r, tthr_r};
        `PMAC_A_STAT: avs_readdata <= {20'h0, ph_r, 2'h0, result_unsec,
                                       alarm_out, first_r, 1'b0, st_r};
        `PMAC_A_RES:  avs_readdata <= res_r;
        default:      avs_readdata <= 32'h0;
      endcase
    end else begin
      avs_waitrequest <= 1'b1;
      if (!avs_waitrequest && avs_write) begin
        case (avs_address)
          `PMAC_A_CTRL: ctrl_r <= avs_writedata[9:0];
          `PMAC_A_MEAS: meas_r <= avs_writedata[15:0];
          `PMAC_A_WAIT: wait_r <= avs_writedata[15:0];
          `PMAC_A_THR:  thr_r  <= avs_writedata; // R15
          `PMAC_A_TEMP: begin
            tthr_r <= avs_writedata[`PMAC_TTHR];
            filt_r <= avs_writedata[`PMAC_FILT]; // R17
          end
          default: ;
        endcase
      end
    end
  end

  // Next measurement state; the power-up run has a fixed one-minute length.
  always @* begin
    st_nxt    = st_r;
    done_nxt  = 1'b0;
    unsec_nxt = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (mode == `PMAC_M_EXT && !ctl_prev_r && ctl_in)
          st_nxt = S_ADJ; // R05
        else if (mode == `PMAC_M_KEY && key_meas)
          st_nxt = S_ADJ; // R07
        else if (mode == `PMAC_M_TIME || mode == `PMAC_M_AUTO)
          st_nxt = S_ADJ;
      end
      S_ADJ: begin
        if (!first_r && mode == `PMAC_M_EXT && ctl_gnd)
          st_nxt = S_IDLE; // R06
        else if (!first_r && mode == `PMAC_M_KEY && key_meas)
          st_nxt = S_IDLE; // R07
        else if (sec_r >= `PMAC_ADJ_S)
          st_nxt = S_MEAS; // R04
      end
      S_MEAS: begin
        if (first_r)
          done_nxt = (sec_r >= `PMAC_FIRST_S - `PMAC_ADJ_S); // R02
        else begin
          case (mode)
            `PMAC_M_TIME: done_nxt = (sec_r >= meas_r); // R03
            `PMAC_M_EXT:  done_nxt = ctl_gnd; // R06
            `PMAC_M_KEY:  done_nxt = key_meas; // R07
            default: begin
              done_nxt  = (sec_r >= `PMAC_AMIN_S && count_ok) ||
                          (sec_r >= `PMAC_AMAX_S); // R08 R09
              unsec_nxt = !count_ok; // R09
            end
          endcase
        end
        if (done_nxt)
          st_nxt = (mode == `PMAC_M_TIME) ? S_WAIT : S_IDLE; // R03
      end
      default: begin
        if (mode != `PMAC_M_TIME)
          st_nxt = S_IDLE;
        else if (sec_r >= wait_r)
          st_nxt = S_ADJ; // R03
      end
    endcase
  end

  // State, seconds in state and the published result.
  always @(posedge clk) begin
    if (reset) begin
      st_r         <= S_ADJ; // R02
      first_r      <= 1'b1;
      sec_r        <= 16'h0;
      ctl_prev_r   <= 1'b1;
      meas_on      <= 1'b0;
      laser_adj    <= 1'b0;
      result_stb   <= 1'b0;
      result_unsec <= 1'b0;
      res_r        <= 32'h0;
      eval_r       <= 1'b0;
    end else begin
      ctl_prev_r <= ctl_in;
      st_r       <= st_nxt;
      if (st_nxt != st_r)
        sec_r <= 16'h0;
      else if (tick_r)
        sec_r <= sec_r + 16'h1;
      meas_on    <= (st_nxt == S_ADJ) || (st_nxt == S_MEAS);
      laser_adj  <= (st_nxt == S_ADJ); // R04
      result_stb <= done_nxt;
      eval_r     <= done_nxt;
      if (done_nxt) begin
        first_r      <= 1'b0;
        res_r        <= class_val; // R17
        result_unsec <= unsec_nxt; // R09
      end
    end
  end

  // Smoothed copies feed only the alarm; published values stay raw.
  pmac_smooth u_smooth (
    .clk    (clk),
    .reset  (reset),
    .upd    (done_nxt),
    .bypass (flow_zero || class_val[7:0] == 8'h00), // R18
    .fk     (filt_r),
    .x      (class_val),
    .s_int  (sm_int)
  );

  // Class conditions against the shared thresholds, temperature against its own.
  always @* begin
    std_c  = 1'b0;
    filt_c = 1'b1;
    any_en = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (thr_r[i*8 +: 8] != 8'h00) begin // R13
        any_en = 1'b1;
        if (sm_int[i*8 +: 8] > thr_r[i*8 +: 8])
          std_c = 1'b1; // R10
        if (!(sm_int[i*8 +: 8] < thr_r[i*8 +: 8]))
          filt_c = 1'b0; // R11
      end
    end
    case (atype)
      `PMAC_T_STD:  cond = std_c; // R10
      `PMAC_T_FILT: cond = any_en && filt_c; // R11 R13
      `PMAC_T_TEMP: cond = (tthr_r != 8'h00) && (temp_val > tthr_r); // R12
      default:      cond = 1'b0;
    endcase
  end

  // Alarm bit: set at a measurement end wins over an acknowledge.
  always @(posedge clk) begin
    if (reset)
      alarm_out <= 1'b0;
    else if (eval_r && !(atype != `PMAC_T_TEMP && res_r == 32'h0)) begin // R14
      if (ctrl_r[`PMAC_LATCH])
        alarm_out <= alarm_out || cond || 1'b0; // R16 R26
      else
        alarm_out <= cond; // R16 R26
    end else if (key_ack && ctrl_r[`PMAC_LATCH])
      alarm_out <= 1'b0; // R16
  end

  // Sequence phases: start, classes, optional flag frames, pause.
  always @(posedge clk) begin
    if (reset) begin
      ph_r   <= P_START;
      psec_r <= 16'h0;
    end else if (aosel != `PMAC_O_SEQ && aosel != `PMAC_O_SEQ2) begin
      ph_r   <= P_START;
      psec_r <= 16'h0;
    end else if (tick_r) begin
      psec_r <= psec_r + 16'h1;
      if ((ph_r == P_START && psec_r + 16'h1 >= `PMAC_SEQS_S) ||
          (ph_r == P_PAUSE && psec_r + 16'h1 >= `PMAC_SEQP_S) ||
          (ph_r != P_START && ph_r != P_PAUSE &&
           psec_r + 16'h1 >= `PMAC_SEQF_S)) begin // R25
        psec_r <= 16'h0;
        if (ph_r == P_PAUSE)
          ph_r <= P_START; // R23
        else if (ph_r == 4'h4 && aosel == `PMAC_O_SEQ)
          ph_r <= P_PAUSE; // R20
        else if (ph_r == 4'h7)
          ph_r <= P_PAUSE; // R21
        else
          ph_r <= ph_r + 4'h1;
      end
    end
  end

  // Loop current for the chosen output; sequences need ISO or SAE.
  always @* begin
    lvl_nxt = iso_ua(res_r[7:0]);
    if (aosel < `PMAC_O_SEQ)
      lvl_nxt = iso_ua(res_r[aosel[1:0]*8 +: 8]); // R19
    else if (aosel == `PMAC_O_NAS)
      lvl_nxt = (nas_class == 8'h00) ? `PMAC_UA_4 :
                `PMAC_UA_5 + {8'h00, nas_class} * `PMAC_UA_1; // R22
    else if (aosel == `PMAC_O_GOST)
      lvl_nxt = (gost_class == 8'h00) ? `PMAC_UA_4 :
                ({8'h00, gost_class} + 16'h0009) * `PMAC_UA_HALF; // R22
    else if (ctrl_r[9]) // R24
      lvl_nxt = iso_ua(res_r[7:0]);
    else begin
      case (ph_r)
        P_START: lvl_nxt = `PMAC_UA_20; // R23
        4'h1:    lvl_nxt = iso_ua(res_r[7:0]); // R20
        4'h2:    lvl_nxt = iso_ua(res_r[15:8]);
        4'h3:    lvl_nxt = iso_ua(res_r[23:16]);
        4'h4:    lvl_nxt = iso_ua(res_r[31:24]);
        4'h5:    lvl_nxt = flag_ua(flags6); // R21
        4'h6:    lvl_nxt = flag_ua(flags7); // R21
        4'h7:    lvl_nxt = flag_ua({alarm_out && atype != `PMAC_T_TEMP,
                                    alarm_out && atype == `PMAC_T_TEMP,
                                    rise_flag}); // R01
        default: lvl_nxt = `PMAC_UA_4; // R23
      endcase
    end
  end

  // The current code is registered so the converter sees clean steps.
  always @(posedge clk) begin
    if (reset)
      iout_ua <= `PMAC_UA_4;
    else
      iout_ua <= lvl_nxt;
  end
endmodule
`default_nettype wire

// ### pmac_checker.sv
// Concurrent checks on the ports of the measurement and alarm block.
`timescale 1ns/1ps
`default_nettype none
`include "pmac_regs.vh"
module pmac_checker #(
  parameter SEC_CYC = 10
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        ctl_in,
  input wire logic        key_meas,
  input wire logic        key_ack,
  input wire logic        meas_on,
  input wire logic        laser_adj,
  input wire logic        result_stb,
  input wire logic        result_unsec,
  input wire logic        alarm_out,
  input wire logic [15:0] iout_ua
);
  logic [1:0]  mode_r;
  logic        first_r;
  logic [31:0] cyc_r;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Mode follows completed control writes; inputs count after the first run.
  always @(posedge clk) begin
    if (reset) begin
      mode_r  <= 2'h0;
      first_r <= 1'b0;
      cyc_r   <= 32'h0;
    end else begin
      cyc_r <= cyc_r + 32'h1;
      if (result_stb) begin
        first_r <= 1'b1;
      end
      if (avs_write && !avs_waitrequest && avs_address == `PMAC_A_CTRL) begin
        mode_r <= avs_writedata[`PMAC_MODE];
      end
    end
  end
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no bus answer");
  AST_BUS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  AST_FIRST_RESULT: assert property (
    result_stb && !first_r |-> cyc_r >= 60 * SEC_CYC - 3 &&
    cyc_r <= 60 * SEC_CYC + 2) else $error("first result late or early");
  AST_EXT_START: assert property (
    first_r && mode_r == `PMAC_M_EXT && !meas_on && $rose(ctl_in)
    |-> ##[1:2] meas_on) else $error("release did not start");
  AST_EXT_STOP: assert property (
    first_r && mode_r == `PMAC_M_EXT && meas_on && !ctl_in
    |-> ##[1:2] !meas_on) else $error("ground did not stop");
  AST_KEY_STOP: assert property (
    first_r && mode_r == `PMAC_M_KEY && meas_on && key_meas
    |-> ##[1:2] !meas_on) else $error("key did not stop");
  AST_ALARM_CAUSE: assert property (
    $changed(alarm_out) |-> $past(result_stb) || $past(result_stb, 2) ||
    $past(key_ack) || $past(key_ack, 2)) else $error("alarm moved alone");
  AST_UNSEC_AUTO: assert property (
    result_stb && result_unsec |-> mode_r == `PMAC_M_AUTO)
    else $error("unsecured outside auto");
  AST_ADJ_IN_MEAS: assert property (laser_adj |-> meas_on)
    else $error("adjust outside run");
  AST_STB_PULSE: assert property (result_stb |=> !result_stb)
    else $error("result pulse too long");
  AST_IOUT_RANGE: assert property (
    iout_ua >= `PMAC_UA_4 && iout_ua <= `PMAC_UA_20)
    else $error("loop current out of range");
  COV_UNSEC: cover property (result_stb && result_unsec);
  COV_ALARM_OFF: cover property ($fell(alarm_out));
  COV_EXT_RUN: cover property (mode_r == `PMAC_M_EXT && $rose(meas_on));
endmodule
bind pmac_top pmac_checker #(.SEC_CYC(SEC_CYC)) u_checker (
  .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_waitrequest, .ctl_in, .key_meas, .key_ack, .meas_on, .laser_adj,
  .result_stb, .result_unsec, .alarm_out, .iout_ua
);
`default_nettype wire

// ### pmac_far.sv
// Loop receiver and external control source at the far side.
`timescale 1ns/1ps
`default_nettype none
module pmac_far (
  input  wire logic        clk,
  input  wire logic        ground_req,
  input  wire logic [15:0] iout_ua,
  output wire logic        ctl_in,
  output var  logic [15:0] loop_ua
);
  logic ctl_r = 1'b0;
  assign ctl_in = ctl_r;
  // The contact moves only after an edge; the receiver reads a cycle late.
  always @(posedge clk) begin
    ctl_r   <= !ground_req;
    loop_ua <= iout_ua;
  end
endmodule
`default_nettype wire

// ### tb.sv
// Bench for the measurement, alarm and loop current block.
`timescale 1ns/1ps
`default_nettype none
`include "pmac_regs.vh"
module tb;
  localparam int S = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] class_val = 32'h0101010A;
  logic [7:0]  temp_val = 8'h00;
  logic        key_meas = 1'b0;
  logic        key_ack = 1'b0;
  logic        count_ok = 1'b0;
  logic        rise_flag = 1'b0;
  logic        flow_zero = 1'b0;
  logic        ground_req = 1'b1;
  logic [2:0]  sel [3] = '{3'h1, 3'h6, 3'h7};
  logic [31:0] avs_readdata, q;
  logic [15:0] iout_ua, loop_ua;
  logic        avs_waitrequest, ctl_in, meas_on, laser_adj;
  logic        result_stb, result_unsec, alarm_out;
  int          err_total = 0;
  int          tests_run = 0;
  int          n;
  pmac_top #(.SEC_CYC(S)) dut (
    .clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .ctl_in, .key_meas, .key_ack,
    .class_val, .nas_class(8'h07), .gost_class(8'h0F), .temp_val,
    .flow_zero, .count_ok, .flags6(3'h5), .flags7(3'h0), .rise_flag,
    .meas_on, .laser_adj, .result_stb, .result_unsec, .alarm_out, .iout_ua
  );
  pmac_far u_far (.clk, .ground_req, .iout_ua, .ctl_in, .loop_ua);
  // The clock toggles every 10 ns, a period of 20 ns.
  always #10 clk = ~clk;
  // One access; the request stands until waitrequest is seen low.
  // An idle edge follows, so a second call never re-raises in the same step.
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic res;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (result_stb !== 1'b1);
  endtask
  // New class values are picked up only when the next run ends.
  task automatic alm(input logic [31:0] cv, input logic e);
    class_val <= cv;
    res;
    repeat (3) @(posedge clk);
    chk(alarm_out, e);
  endtask
  task automatic wait_ua(input logic [15:0] v);
    do @(posedge clk); while (loop_ua !== v);
  endtask
  task automatic press(input logic ack);
    key_ack  <= ack;
    key_meas <= !ack;
    @(posedge clk);
    key_ack  <= 1'b0;
    key_meas <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The whole run needs about 9000 cycles; this allows well over half again.
  initial begin
    #300000;
    err_total++;
    conclude;
  end
  // Registers, alarm types, analog selections, then the control modes.
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(1'b0, `PMAC_A_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `PMAC_A_TEMP, 32'h0);
    chk(q[15:8], 32'h02);
    bus(1'b0, 4'hF, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `PMAC_A_MEAS, 32'h5);
    bus(1'b1, `PMAC_A_WAIT, 32'h3);
    bus(1'b1, `PMAC_A_THR, 32'h5);
    bus(1'b1, `PMAC_A_TEMP, 32'h100);
    $display("register test done");
    alm(32'h0101010A, 1'b1);
    alm(32'h0, 1'b1);
    alm(32'h01010102, 1'b0);
    chk(n >= 105 && n <= 109, 1'b1);
    bus(1'b1, `PMAC_A_TEMP, 32'h200);
    flow_zero <= 1'b1;
    alm(32'h01010108, 1'b1);
    flow_zero <= 1'b0;
    alm(32'h01010104, 1'b1);
    bus(1'b1, `PMAC_A_CTRL, 32'h4);
    alm(32'h01010102, 1'b1);
    bus(1'b1, `PMAC_A_CTRL, 32'h10);
    alm(32'h01010102, 1'b1);
    press(1'b1);
    chk(alarm_out, 1'b0);
    temp_val <= 8'h32;
    bus(1'b1, `PMAC_A_CTRL, 32'h8);
    bus(1'b1, `PMAC_A_TEMP, 32'h100);
    alm(32'h0D0D0D0D, 1'b0);
    bus(1'b1, `PMAC_A_TEMP, 32'h128);
    alm(32'h0D0D0D0D, 1'b1);
    $display("alarm test done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `PMAC_A_CTRL, {24'h0, sel[i], 5'h08});
      repeat (4) @(posedge clk);
      chk(loop_ua, 16'h2EE0);
    end
    bus(1'b1, `PMAC_A_CTRL, 32'h288);
    repeat (4) @(posedge clk);
    chk(loop_ua, 16'h2EE0);
    rise_flag <= 1'b1;
    bus(1'b1, `PMAC_A_CTRL, 32'hA8);
    wait_ua(16'h0FA0);
    wait_ua(16'h4E20);
    repeat (25) @(posedge clk);
    chk(loop_ua, 16'h2EE0);
    repeat (80) @(posedge clk);
    chk(loop_ua, 16'h2328);
    repeat (40) @(posedge clk);
    chk(loop_ua, 16'h32C8);
    repeat (20) @(posedge clk);
    chk(loop_ua, 16'h0FA0);
    $display("analog test done");
    bus(1'b1, `PMAC_A_CTRL, 32'h8);
    while (meas_on !== 1'b0) @(posedge clk);
    bus(1'b1, `PMAC_A_CTRL, 32'h9);
    ground_req <= 1'b0;
    repeat (6) @(posedge clk);
    chk(meas_on, 1'b1);
    ground_req <= 1'b1;
    repeat (6) @(posedge clk);
    chk(meas_on, 1'b0);
    bus(1'b1, `PMAC_A_CTRL, 32'hA);
    press(1'b0);
    chk(meas_on, 1'b1);
    chk(laser_adj, 1'b1);
    press(1'b0);
    chk(meas_on, 1'b0);
    $display("external and key test done");
    bus(1'b1, `PMAC_A_CTRL, 32'hB);
    res;
    res;
    chk(n >= 3028 && n <= 3032, 1'b1);
    chk(result_unsec, 1'b1);
    count_ok <= 1'b1;
    res;
    chk(n >= 478 && n <= 482, 1'b1);
    repeat (2) @(posedge clk);
    chk(result_unsec, 1'b0);
    $display("automatic test done");
    conclude;
  end
endmodule
`default_nettype wire
